// ### common/asop_pkg.sv
package asop_pkg;

  //--------------------------------------------------------------
  // Word format
  //--------------------------------------------------------------
  localparam int          WORD_W   = 12;
  localparam int          RAW_W    = 14;
  localparam logic [11:0] POS_FULL = 12'h7FF;
  localparam logic [11:0] NEG_FULL = 12'h800;
  localparam logic [11:0] ZERO_W   = 12'h000;

  //--------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------
  localparam int LATENCY      = 10;
  localparam int FIFO_DEPTH   = 8;
  localparam int CLK_HZ       = 20_000_000;
  localparam int SETTLE_NS    = 200;
  localparam int SETTLE_CYC_T = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_CYC   = (SETTLE_CYC_T > LATENCY) ? SETTLE_CYC_T : LATENCY;
  localparam int CNT_W        = 5;
  localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CYC);

endpackage : asop_pkg

// ### design/asop_fifo.sv
`timescale 1ns/1ps
module asop_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,    // Clock
  input  wire logic             rst_n_i,  // Async reset, low
  input  wire logic [WIDTH-1:0] in_data_i, // Write data
  input  wire logic             in_valid_i, // Write valid
  output logic                  in_ready_o, // Not full
  output logic [WIDTH-1:0]      out_data_o, // Head data
  output logic                  out_valid_o, // Not empty
  input  wire logic             out_ready_i  // Drain accept
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];

  always_comb
  begin
    push    = in_valid_i && in_ready_o;
    pop     = out_valid_o && out_ready_i;
    nxt_mem = mem_ff;
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_mem[wr_ff] = in_data_i;
      nxt_wr         = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop)
      nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
    if (push && !pop)
      nxt_cnt = cnt_ff + 1'b1;
    else if (pop && !push)
      nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_ff <= '{default: '0};
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : asop_fifo

// ### design/asop_top.sv
`timescale 1ns/1ps
module asop_top (
  input  wire logic        SYS_CLK_I,         // Sample clock, rising edge samples
  input  wire logic        RST_N_I,           // Async reset, low
  input  wire logic [13:0] ANALOG_INPUT_PAIR_I, // Quantised input, signed, may exceed range
  input  wire logic        CAPTURE_READY_I,   // Capture side accepts word
  output logic [11:0]      SAMPLE_WORD_BITS_O, // Twos-complement word
  output logic             OUT_OF_RANGE_O,    // Word at full scale
  output logic             WORD_VALID_O,      // Word holds a settled sample
  output logic             INPUT_READY_O      // Buffer can take a sample
);

  //--------------------------------------------------------------
  // Input synchroniser, from outside the clock domain
  //--------------------------------------------------------------
  // Only the second stage feeds logic; the first may be metastable
  logic [13:0] sync1_ff;
  logic [13:0] sync2_ff;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= ANALOG_INPUT_PAIR_I;
      sync2_ff <= sync1_ff;
    end
  end

  //--------------------------------------------------------------
  // Quantiser: clamp and flag
  //--------------------------------------------------------------
  // Inclusive bounds: an exact full-scale input raises the flag too
  function automatic logic [12:0] clamp_word(input logic signed [13:0] raw);
    logic [12:0] res;
    res = {1'b0, asop_pkg::ZERO_W};
    if (raw >= $signed({2'b00, asop_pkg::POS_FULL}))
      res = {1'b1, asop_pkg::POS_FULL};
    else if (raw <= $signed({2'b11, asop_pkg::NEG_FULL}))
      res = {1'b1, asop_pkg::NEG_FULL};
    else
      res = {1'b0, raw[11:0]};
    return res;
  endfunction : clamp_word

  //--------------------------------------------------------------
  // Pipeline: word and flag travel together
  //--------------------------------------------------------------
  // Stage 0 takes the sample on the rising edge; the last stage
  // feeds the output buffer, nine edges after stage 0 takes it.
  logic [12:0] pipe_ff  [asop_pkg::LATENCY];
  logic [12:0] nxt_pipe [asop_pkg::LATENCY];
  // Latency budget: two sync edges, ten stages, buffer write,
  // output register; capture logic must count the full total.
  logic [12:0] fifo_head;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        pipe_adv;
  logic        out_take;

  // Stall the pipe when the buffer is full; back-pressure stops sampling
  assign pipe_adv = fifo_in_ready;

  always_comb
  begin
    nxt_pipe = pipe_ff;
    if (pipe_adv)
    begin
      nxt_pipe[0] = clamp_word($signed(sync2_ff));
      for (int i = 1; i < asop_pkg::LATENCY; i++)
        nxt_pipe[i] = pipe_ff[i-1];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      pipe_ff <= '{default: '0};
    else
      pipe_ff <= nxt_pipe;
  end

  //--------------------------------------------------------------
  // Settling counter after reset
  //--------------------------------------------------------------
  // Reset stands in for power-up; a stopped clock cannot be seen
  // from inside this domain, so the user must reset after one.
  logic [asop_pkg::CNT_W-1:0] settle_ff;
  logic [asop_pkg::CNT_W-1:0] nxt_settle;
  logic                       settled;

  assign settled = (settle_ff == asop_pkg::SETTLE_LAST);

  always_comb
  begin
    nxt_settle = settle_ff;
    if (!settled && pipe_adv)
      nxt_settle = settle_ff + 1'b1;
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      settle_ff <= '0;
    else
      settle_ff <= nxt_settle;
  end

  //--------------------------------------------------------------
  // Output buffer
  //--------------------------------------------------------------
  asop_fifo #(
    .WIDTH (13),
    .DEPTH (asop_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (SYS_CLK_I),
    .rst_n_i     (RST_N_I),
    .in_data_i   (pipe_ff[asop_pkg::LATENCY-1]),
    .in_valid_i  (settled),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_head),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (out_take)
  );

  //--------------------------------------------------------------
  // Output register
  //--------------------------------------------------------------
  // Flag and word load in the same edge so they never split
  logic [11:0] word_ff;
  logic [11:0] nxt_word;
  logic        or_ff;
  logic        nxt_or;
  logic        vld_ff;
  logic        nxt_vld;
  logic        rdy_ff;
  logic        nxt_rdy;

  // Load when the output slot is empty or being taken
  assign out_take = fifo_out_valid && (!vld_ff || CAPTURE_READY_I);

  always_comb
  begin
    nxt_word = word_ff;
    nxt_or   = or_ff;
    nxt_vld  = vld_ff;
    if (out_take)
    begin
      nxt_word = fifo_head[11:0];
      nxt_or   = fifo_head[12];
      nxt_vld  = 1'b1;
    end
    else if (CAPTURE_READY_I)
      nxt_vld = 1'b0;
    nxt_rdy = fifo_in_ready;
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      word_ff <= '0;
      or_ff   <= 1'b0;
      vld_ff  <= 1'b0;
      rdy_ff  <= 1'b0;
    end
    else
    begin
      word_ff <= nxt_word;
      or_ff   <= nxt_or;
      vld_ff  <= nxt_vld;
      rdy_ff  <= nxt_rdy;
    end
  end

  //--------------------------------------------------------------
  // Output drive
  //--------------------------------------------------------------
  // Ready is one cycle late; the buffer slack absorbs that lag
  assign SAMPLE_WORD_BITS_O = word_ff;
  assign OUT_OF_RANGE_O     = or_ff;
  assign WORD_VALID_O       = vld_ff;
  assign INPUT_READY_O      = rdy_ff;

endmodule : asop_top

// ### tb/adc_sample_output_port_tb.sv
`timescale 1ns/1ps
module adc_sample_output_port_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] analog_input_pair = 14'h0123;
  logic        stall = 1'b0;
  logic        rdy, flag, vld, in_rdy;
  logic [11:0] word;
  int          errors = 0;
  int          checks = 0;
  logic [13:0] ins [13] = '{14'h0000, 14'h0001, 14'h3FFF, 14'h07FE, 14'h07FF, 14'h0800, 14'h1FFF,
                            14'h0005, 14'h3801, 14'h3800, 14'h37FF, 14'h2000, 14'h3FFE};
  logic [12:0] exps [13] = '{13'h0000, 13'h0001, 13'h0FFF, 13'h07FE, 13'h17FF, 13'h17FF, 13'h17FF,
                             13'h0005, 13'h0801, 13'h1800, 13'h1800, 13'h1800, 13'h0FFE};
  always #25 clk = ~clk;
  asop_top i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ANALOG_INPUT_PAIR_I(analog_input_pair), .CAPTURE_READY_I(rdy),
    .SAMPLE_WORD_BITS_O(word), .OUT_OF_RANGE_O(flag), .WORD_VALID_O(vld), .INPUT_READY_O(in_rdy));
  asop_capture i_cap (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .valid_i(vld), .word_i(word),
    .flag_i(flag), .ready_o(rdy));
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic t_codes();
    logic [12:0] q [$];
    repeat (20) @(posedge clk);
    i_cap.got_q.delete();
    foreach (ins[i]) @(posedge clk) analog_input_pair <= ins[i];
    @(posedge clk) analog_input_pair <= 14'h0123;
    repeat (30) @(posedge clk);
    // Marker words are padding from the idle input
    foreach (i_cap.got_q[i]) if (i_cap.got_q[i] !== 13'h0123) q.push_back(i_cap.got_q[i]);
    chk(13'(q.size()), 13'h000D);
    foreach (exps[i]) chk(q[i], exps[i]);
    $display("codes done");
  endtask : t_codes
  task automatic t_lat();
    // One edge is already spent restoring the idle input
    int n = 1;
    @(posedge clk) analog_input_pair <= 14'h0456;
    @(posedge clk) analog_input_pair <= 14'h0123;
    while (word !== 12'h456 && n < 40)
    begin
      @(posedge clk) #1;
      n++;
    end
    chk(13'(n), 13'h000E);
    if (n >= 40) print_verdict();
    $display("latency done");
  endtask : t_lat
  task automatic t_stall();
    int n = 0;
    // Alternate words so a held output differs from the buffer head
    repeat (16) @(posedge clk) analog_input_pair <= analog_input_pair ^ 14'h0001;
    @(posedge clk) stall <= 1'b1;
    while (in_rdy !== 1'b0 && n < 40)
    begin
      @(posedge clk) #1;
      n++;
    end
    chk(13'({vld, in_rdy}), 13'h0002);
    if (n >= 40) print_verdict();
    @(posedge clk) stall <= 1'b0;
    while (in_rdy !== 1'b1 && n < 80)
    begin
      @(posedge clk) #1;
      n++;
    end
    chk(13'({vld, in_rdy}), 13'h0003);
    if (n >= 80) print_verdict();
    $display("stall done");
  endtask : t_stall
  task automatic t_settle();
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10)
    begin
      @(posedge clk) #1;
      chk({vld, word}, 13'h0000);
    end
    $display("settle done");
  endtask : t_settle
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_codes();
    t_lat();
    t_stall();
    t_settle();
    print_verdict();
  end
endmodule : adc_sample_output_port_tb

// ### tb/asop_capture.sv
`timescale 1ns/1ps
module asop_capture (
  input  wire logic        clk_i,   // Sample clock
  input  wire logic        rst_n_i, // Reset, low
  input  wire logic        stall_i, // Bench stall request
  input  wire logic        valid_i, // Word valid
  input  wire logic [11:0] word_i,  // Sample word
  input  wire logic        flag_i,  // Range flag
  output logic             ready_o  // Capture accepts
);
  logic [12:0] got_q [$];
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ready_o <= 1'b0;
    else
    begin
      ready_o <= !stall_i;
      if (valid_i && ready_o)
        got_q.push_back({flag_i, word_i});
    end
  end
endmodule : asop_capture

// ### tb/asop_top_assertions.sv
`timescale 1ns/1ps
module asop_top_assertions (
  input wire logic        SYS_CLK_I,           // Clock
  input wire logic        RST_N_I,             // Reset, low
  input wire logic [13:0] ANALOG_INPUT_PAIR_I, // Input
  input wire logic        CAPTURE_READY_I,     // Accept
  input wire logic [11:0] SAMPLE_WORD_BITS_O,  // Word
  input wire logic        OUT_OF_RANGE_O,      // Flag
  input wire logic        WORD_VALID_O,        // Valid
  input wire logic        INPUT_READY_O        // Not full
);
  logic [3:0] nxt_cnt;
  logic [3:0] cnt_ff;
  logic       full;
  assign full = (SAMPLE_WORD_BITS_O == asop_pkg::POS_FULL) || (SAMPLE_WORD_BITS_O == asop_pkg::NEG_FULL);
  // Saturates so early-cycle checks never wrap
  always_comb nxt_cnt = (cnt_ff == 4'hF) ? cnt_ff : cnt_ff + 4'h1;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  flag_full_a: assert property (WORD_VALID_O && full |-> OUT_OF_RANGE_O)
    else $error("flag low at full scale");
  flag_clear_a: assert property (WORD_VALID_O && !full |-> !OUT_OF_RANGE_O)
    else $error("flag high in range");
  sat_code_a: assert property (WORD_VALID_O && OUT_OF_RANGE_O |->
    SAMPLE_WORD_BITS_O[10:0] == {11{!SAMPLE_WORD_BITS_O[11]}}) else $error("word not clamped");
  pair_hold_a: assert property (WORD_VALID_O && !CAPTURE_READY_I |=>
    $stable(SAMPLE_WORD_BITS_O) && $stable(OUT_OF_RANGE_O)) else $error("word moved in stall");
  valid_hold_a: assert property (WORD_VALID_O && !CAPTURE_READY_I |=> WORD_VALID_O)
    else $error("valid dropped in stall");
  settle_gap_a: assert property (cnt_ff < 4'hA |-> !WORD_VALID_O)
    else $error("word during settle");
  // Ten settle advances, buffer write, output register
  first_word_a: assert property (cnt_ff < 4'hC |-> !WORD_VALID_O)
    else $error("word before latency");
  fill_stop_a: assert property ((WORD_VALID_O && !CAPTURE_READY_I) [*8] |-> ##[0:4] !INPUT_READY_O)
    else $error("input taken while full");
  cover property (WORD_VALID_O && CAPTURE_READY_I && OUT_OF_RANGE_O);
  cover property (!INPUT_READY_O);
  cover property ($fell(OUT_OF_RANGE_O));
endmodule : asop_top_assertions
bind asop_top asop_top_assertions i_chk (.SYS_CLK_I, .RST_N_I, .ANALOG_INPUT_PAIR_I, .CAPTURE_READY_I,
  .SAMPLE_WORD_BITS_O, .OUT_OF_RANGE_O, .WORD_VALID_O, .INPUT_READY_O);
